// >>> core/lfc_cfg_bank.sv
// Fault-check configuration register bank with Avalon-MM slave and non-volatile reload
//
// Function
// - Four fault-check enable registers are decoded at indexes 70h, 71h, 72h and 73h for A/B, C/D, E/F and G/H.
// - Every per-channel enable bit reads and writes, 0 turning checking off and 1 turning it on.
// - After reset every enable bit is filled from the non-volatile copy, not from a constant.
// - In the A/B register bit 5 is b_1, bit 4 is b_0, bit 1 is a_1 and bit 0 is a_0.
// - In the C/D register bit 5 is d_1, bit 4 is d_0, bit 1 is c_1 and bit 0 is c_0.
// - In the E/F register bit 5 is f_1, bit 4 is f_0, bit 1 is e_1 and bit 0 is e_0.
// - In the G/H register bit 5 is h_1, bit 4 is h_0, bit 1 is g_1 and bit 0 is g_0.
module lfc_cfg_bank #(
	parameter int ADDR_W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic nvm_rd,
	output logic [4:0] nvm_slot,
	input wire logic [7:0] nvm_rdata,
	input wire logic nvm_valid,
	output lfc_pkg::lfc_check_on_t check_on,
	output logic [7:0] cfg_bytes [lfc_pkg::REG_COUNT]
);

	lfc_pkg::lfc_core_state_t st_ff;
	lfc_pkg::lfc_core_state_t nxt_st;

	logic [7:0] reg_q [lfc_pkg::REG_COUNT];
	logic [7:0] word_idx;
	logic [7:0] rel_idx;
	logic [4:0] hit_slot;
	logic in_bank;
	logic is_status;
	logic wr_go;
	logic rd_go;
	logic byte_lane;
	logic load_go;
	logic reload_req;
	logic [7:0] rd_byte;

	// Word addressing: the two low byte-address bits are not decoded
	assign word_idx = avs_address[ADDR_W-1:2];
	assign rel_idx = word_idx - lfc_pkg::IDX_FIRST;
	assign in_bank = (word_idx >= lfc_pkg::IDX_FIRST) &&
		(rel_idx < 8'(lfc_pkg::REG_COUNT));
	assign hit_slot = rel_idx[4:0];
	assign is_status = (word_idx == lfc_pkg::IDX_BANK_STATUS);
	assign byte_lane = avs_byteenable[0];

	// Bus stalls until the non-volatile copy is in, so software never sees a half-filled bank
	assign avs_waitrequest = !st_ff.done || (avs_read && !st_ff.rd_ack);
	assign wr_go = avs_write && !avs_waitrequest && byte_lane;
	assign rd_go = avs_read && !st_ff.rd_ack && st_ff.done;
	assign load_go = st_ff.st == lfc_pkg::LD_FETCH && nvm_valid;
	assign reload_req = wr_go && is_status && avs_writedata[lfc_pkg::STAT_RELOAD_BIT];

	// One register per map slot; unmapped indexes have no storage and drop writes
	genvar gi;
	generate
		for (gi = 0; gi < lfc_pkg::REG_COUNT; gi++) begin : g_reg
			lfc_cfg_byte #(
				.WMASK(lfc_pkg::slot_mask(gi))
			) u_byte (
				.clk(clk),
				.rst_n(rst_n),
				.load(load_go && st_ff.slot == 5'(gi)),
				.load_data(nvm_rdata),
				.wr(wr_go && in_bank && hit_slot == 5'(gi)),
				.wr_data(avs_writedata[7:0]),
				.q(reg_q[gi])
			);
		end
	endgenerate

	// Read mux; reserved bits already sit at zero in storage
	always_comb begin
		rd_byte = lfc_pkg::BYTE_RESET;
		if (in_bank)
			rd_byte = reg_q[hit_slot];
		else if (is_status) begin
			rd_byte[lfc_pkg::STAT_DONE_BIT] = st_ff.done;
		end
	end

	// Loader fetches one byte per request with a gap cycle so the slot settles
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rd_ack = rd_go;
		if (rd_go)
			nxt_st.rdata = {24'h00_0000, rd_byte};
		unique case (st_ff.st)
			lfc_pkg::LD_GAP: begin
				nxt_st.st = lfc_pkg::LD_FETCH;
				nxt_st.nvm_rd = 1'b1;
			end
			lfc_pkg::LD_FETCH: begin
				if (nvm_valid) begin
					nxt_st.nvm_rd = 1'b0;
					if (st_ff.slot == lfc_pkg::LAST_SLOT) begin
						nxt_st.st = lfc_pkg::LD_DONE;
						nxt_st.done = 1'b1;
					end else begin
						nxt_st.st = lfc_pkg::LD_GAP;
						nxt_st.slot = st_ff.slot + 5'h01;
					end
				end
			end
			lfc_pkg::LD_DONE: begin
				if (reload_req) begin
					nxt_st.st = lfc_pkg::LD_GAP;
					nxt_st.slot = 5'h00;
					nxt_st.done = 1'b0;
				end
			end
			default: begin
				nxt_st.st = lfc_pkg::LD_GAP;
				nxt_st.slot = 5'h00;
				nxt_st.nvm_rd = 1'b0;
				nxt_st.done = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= '{
				st: lfc_pkg::LD_GAP,
				slot: 5'h00,
				nvm_rd: 1'b0,
				done: 1'b0,
				rd_ack: 1'b0,
				rdata: lfc_pkg::WORD_ZERO
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign avs_readdata = st_ff.rdata;
	assign nvm_rd = st_ff.nvm_rd;
	assign nvm_slot = st_ff.slot;

	always_comb begin
		for (int i = 0; i < lfc_pkg::REG_COUNT; i++) begin
			cfg_bytes[i] = reg_q[i];
		end
	end

	// Channel enables straight from the stored bits
	localparam int S_AB = 0;
	localparam int S_CD = 1;
	localparam int S_EF = 2;
	localparam int S_GH = 3;

	assign check_on.check_on_a_0 = reg_q[S_AB][lfc_pkg::BIT_LO_0];
	assign check_on.check_on_a_1 = reg_q[S_AB][lfc_pkg::BIT_LO_1];
	assign check_on.check_on_b_0 = reg_q[S_AB][lfc_pkg::BIT_HI_0];
	assign check_on.check_on_b_1 = reg_q[S_AB][lfc_pkg::BIT_HI_1];
	assign check_on.check_on_c_0 = reg_q[S_CD][lfc_pkg::BIT_LO_0];
	assign check_on.check_on_c_1 = reg_q[S_CD][lfc_pkg::BIT_LO_1];
	assign check_on.check_on_d_0 = reg_q[S_CD][lfc_pkg::BIT_HI_0];
	assign check_on.check_on_d_1 = reg_q[S_CD][lfc_pkg::BIT_HI_1];
	assign check_on.check_on_e_0 = reg_q[S_EF][lfc_pkg::BIT_LO_0];
	assign check_on.check_on_e_1 = reg_q[S_EF][lfc_pkg::BIT_LO_1];
	assign check_on.check_on_f_0 = reg_q[S_EF][lfc_pkg::BIT_HI_0];
	assign check_on.check_on_f_1 = reg_q[S_EF][lfc_pkg::BIT_HI_1];
	assign check_on.check_on_g_0 = reg_q[S_GH][lfc_pkg::BIT_LO_0];
	assign check_on.check_on_g_1 = reg_q[S_GH][lfc_pkg::BIT_LO_1];
	assign check_on.check_on_h_0 = reg_q[S_GH][lfc_pkg::BIT_HI_0];
	assign check_on.check_on_h_1 = reg_q[S_GH][lfc_pkg::BIT_HI_1];

endmodule

// >>> include/lfc_pkg.sv
// Constants, types and field layout shared by the fault-check configuration bank
package lfc_pkg;

	// Register indexes; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_FIRST = 8'h70;
	localparam logic [7:0] IDX_ENABLE_AB = 8'h70;
	localparam logic [7:0] IDX_ENABLE_CD = 8'h71;
	localparam logic [7:0] IDX_ENABLE_EF = 8'h72;
	localparam logic [7:0] IDX_ENABLE_GH = 8'h73;
	localparam logic [7:0] IDX_SHORT_PICK_AB = 8'h74;
	localparam logic [7:0] IDX_SHORT_PICK_CD = 8'h75;
	localparam logic [7:0] IDX_SHORT_PICK_EF = 8'h76;
	localparam logic [7:0] IDX_SHORT_PICK_GH = 8'h77;
	localparam logic [7:0] IDX_SHORT_LEVEL_0 = 8'h78;
	localparam logic [7:0] IDX_SHORT_LEVEL_1 = 8'h79;
	localparam logic [7:0] IDX_REFERENCE = 8'h7a;
	localparam logic [7:0] IDX_CHECK_SETTING = 8'h7b;
	localparam logic [7:0] IDX_REPORT_MASK = 8'h7c;
	localparam logic [7:0] IDX_CHANNEL_MASK = 8'h7d;
	localparam logic [7:0] IDX_BRIGHTNESS = 8'h7e;
	localparam logic [7:0] IDX_BRIGHTNESS_SPARE = 8'h7f;
	localparam logic [7:0] IDX_SAFE_MAP_AB = 8'h80;
	localparam logic [7:0] IDX_SAFE_MAP_CD = 8'h81;
	localparam logic [7:0] IDX_SAFE_MAP_EF = 8'h82;
	localparam logic [7:0] IDX_SAFE_MAP_GH = 8'h83;
	localparam logic [7:0] IDX_LINK_PARAM_0 = 8'h84;
	localparam logic [7:0] IDX_LINK_PARAM_1 = 8'h85;
	localparam logic [7:0] IDX_LINK_PARAM_2 = 8'h86;
	localparam logic [7:0] IDX_CHECKSUM = 8'h87;
	localparam logic [7:0] IDX_BANK_STATUS = 8'h88;
	localparam int REG_COUNT = 24;
	localparam logic [4:0] LAST_SLOT = 5'h17;

	// Field positions inside each fault-check enable register
	localparam int BIT_HI_1 = 5;
	localparam int BIT_HI_0 = 4;
	localparam int BIT_LO_1 = 1;
	localparam int BIT_LO_0 = 0;
	localparam logic [7:0] ENABLE_MASK = 8'h33;
	localparam logic [7:0] FULL_MASK = 8'hff;
	localparam logic [7:0] NONE_MASK = 8'h00;

	// Bank status register fields
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_RELOAD_BIT = 1;

	// Value held before the non-volatile copy arrives
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// Writable bits of the register in a given slot
	function automatic logic [7:0] slot_mask(input int slot);
		logic [7:0] idx;
		idx = IDX_FIRST + 8'(slot);
		if (idx <= IDX_ENABLE_GH)
			return ENABLE_MASK;
		else if (idx == IDX_BRIGHTNESS_SPARE)
			return NONE_MASK;
		else
			return FULL_MASK;
	endfunction

	typedef enum logic [2:0] {
		LD_GAP = 3'b001,
		LD_FETCH = 3'b010,
		LD_DONE = 3'b100
	} lfc_load_st_t;

	typedef struct packed {
		lfc_load_st_t st;
		logic [4:0] slot;
		logic nvm_rd;
		logic done;
		logic rd_ack;
		logic [31:0] rdata;
	} lfc_core_state_t;

	typedef struct packed {
		logic [7:0] q;
	} lfc_byte_state_t;

	typedef struct packed {
		logic check_on_a_0;
		logic check_on_a_1;
		logic check_on_b_0;
		logic check_on_b_1;
		logic check_on_c_0;
		logic check_on_c_1;
		logic check_on_d_0;
		logic check_on_d_1;
		logic check_on_e_0;
		logic check_on_e_1;
		logic check_on_f_0;
		logic check_on_f_1;
		logic check_on_g_0;
		logic check_on_g_1;
		logic check_on_h_0;
		logic check_on_h_1;
	} lfc_check_on_t;

endpackage

// >>> core/lfc_cfg_byte.sv
// One byte-wide configuration register with a writable-bit mask
module lfc_cfg_byte #(
	parameter logic [7:0] WMASK = 8'hff
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [7:0] load_data,
	input wire logic wr,
	input wire logic [7:0] wr_data,
	output logic [7:0] q
);

	lfc_pkg::lfc_byte_state_t st_ff;
	lfc_pkg::lfc_byte_state_t nxt_st;

	// Masked bits stay zero whatever the source
	always_comb begin
		nxt_st = st_ff;
		if (load)
			nxt_st.q = load_data & WMASK;
		else if (wr)
			nxt_st.q = wr_data & WMASK;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			st_ff <= '{q: lfc_pkg::BYTE_RESET};
		else
			st_ff <= nxt_st;
	end

	assign q = st_ff.q;

endmodule

// >>> test/lfc_cfg_bank_checker.sv
// Bound port checker for the fault-check configuration bank
module lfc_chk #(
	parameter int ADDR_W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic nvm_rd,
	input wire logic [4:0] nvm_slot,
	input wire logic [7:0] nvm_rdata,
	input wire logic nvm_valid,
	input wire lfc_pkg::lfc_check_on_t check_on,
	input wire logic [7:0] cfg_bytes [lfc_pkg::REG_COUNT]
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire [15:0] co = check_on;
	wire hit = avs_address[9:4] == 6'h1c;
	wire [1:0] ri = avs_address[3:2];
	sequence fetch;
		nvm_rd && nvm_valid;
	endsequence
	sequence gap_next;
		!nvm_rd ##1 nvm_rd;
	endsequence
	chk_map_ab: assert property ({co[12], co[13], co[14], co[15]} == {cfg_bytes[0][5:4], cfg_bytes[0][1:0]})
		else $error("ab map wrong");
	chk_map_cd: assert property ({co[8], co[9], co[10], co[11]} == {cfg_bytes[1][5:4], cfg_bytes[1][1:0]})
		else $error("cd map wrong");
	chk_map_ef: assert property ({co[4], co[5], co[6], co[7]} == {cfg_bytes[2][5:4], cfg_bytes[2][1:0]})
		else $error("ef map wrong");
	chk_map_gh: assert property ({co[0], co[1], co[2], co[3]} == {cfg_bytes[3][5:4], cfg_bytes[3][1:0]})
		else $error("gh map wrong");
	chk_rsvd_zero: assert property (((cfg_bytes[0] | cfg_bytes[1] | cfg_bytes[2] | cfg_bytes[3]) & 8'hcc) == 8'h00)
		else $error("reserved bit set");
	chk_wr_store: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] && hit |=>
		cfg_bytes[$past(ri)] == ($past(avs_writedata[7:0]) & 8'h33))
		else $error("write not stored");
	chk_rd_data: assert property (avs_read && !avs_waitrequest && hit |-> avs_readdata == {24'h0, cfg_bytes[ri]})
		else $error("read data wrong");
	chk_load_store: assert property (fetch ##0 nvm_slot < 5'h4 |=> cfg_bytes[$past(nvm_slot)] == ($past(nvm_rdata) & 8'h33))
		else $error("load byte lost");
	chk_load_gap: assert property (fetch ##0 nvm_slot != 5'h17 |=> gap_next)
		else $error("load did not step on");
endmodule

bind lfc_cfg_bank lfc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// >>> test/lfc_cfg_bank_tb.sv
// Self-checking bench for the fault-check configuration bank
module lfc_cfg_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic nvm_rd;
	logic [4:0] nvm_slot;
	logic [7:0] nvm_rdata = 8'h00;
	logic nvm_valid = 1'h0;
	lfc_pkg::lfc_check_on_t check_on;
	logic [7:0] cfg_bytes [lfc_pkg::REG_COUNT];
	logic [31:0] got;
	int n_errors = 0;
	int checks_done = 0;
	lfc_cfg_bank uut (.*);
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic logic [7:0] nv(input int s);
		return 8'(8'ha5 + s);
	endfunction
	function automatic logic [7:0] mk(input int s);
		return s < 4 ? 8'h33 : (s == 15 ? 8'h00 : 8'hff);
	endfunction
	// Idle data is flipped so a stale byte never passes for a fresh one
	always @(posedge clk) begin
		nvm_valid <= nvm_rd && !nvm_valid;
		nvm_rdata <= (nvm_rd && !nvm_valid) ? nv(nvm_slot) : ~nvm_rdata;
	end
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, seen);
		end
	endtask
	// Request stands until waitrequest is seen low at a rising edge; a hang is left to the watchdog
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		avs_address <= {idx, 2'h0};
		avs_writedata <= {24'h0, d};
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		got = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	task automatic t_load();
		for (int s = 0; s < 24; s++) begin
			bus(1'h0, 8'h70 + 8'(s), 8'h00);
			cmp("load", {24'h0, nv(s) & mk(s)}, got);
		end
	endtask
	task automatic t_bits();
		int b;
		logic [7:0] a;
		for (int r = 0; r < 4; r++)
			bus(1'h1, 8'h70 + 8'(r), 8'h00);
		for (int r = 0; r < 4; r++) begin
			a = 8'h70 + 8'(r);
			for (int j = 0; j < 4; j++) begin
				b = j < 2 ? j : j + 2;
				bus(1'h1, a, 8'h01 << b);
				@(negedge clk);
				cmp("check_on", 32'(16'h8000 >> (4 * r + j)), 32'(check_on));
				bus(1'h0, a, 8'h00);
				cmp("bit", 32'(8'h01 << b), got);
			end
			bus(1'h1, a, 8'hff);
			bus(1'h0, a, 8'h00);
			cmp("full", 32'h33, got);
			bus(1'h1, a, 8'h00);
		end
	endtask
	task automatic t_edge();
		avs_byteenable <= 4'he;
		bus(1'h1, 8'h71, 8'h33);
		avs_byteenable <= 4'hf;
		bus(1'h0, 8'h71, 8'h00);
		cmp("byteenable", 32'h0, got);
		bus(1'h1, 8'h7f, 8'hff);
		bus(1'h0, 8'h7f, 8'h00);
		cmp("spare", 32'h0, got);
		// Offsets outside the map are only ever read, never written
		bus(1'h0, 8'h60, 8'h00);
		cmp("unmapped", 32'h0, got);
		bus(1'h1, 8'h74, 8'h5a);
		bus(1'h0, 8'h70, 8'h00);
		cmp("neighbour", 32'h0, got);
	endtask
	task automatic t_reload();
		bus(1'h1, 8'h88, 8'h02);
		t_load();
		bus(1'h0, 8'h88, 8'h00);
		cmp("status", 32'h1, got);
	endtask
	task automatic t_reset();
		bus(1'h1, 8'h71, 8'h00);
		rst_n <= 1'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		t_load();
		cmp("check_on load", 32'h95d1, 32'(check_on));
	endtask
	task automatic close_out();
		if (n_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		t_load();
		t_bits();
		t_edge();
		t_reload();
		t_reset();
		close_out();
	end
	initial begin
		#50us;
		n_errors++;
		close_out();
	end
endmodule
